// file: hdl/wips_pkg.sv
// constants, types and register map of the packet switch
// assumes one 100 MHz system clock and one shared, slower link clock
package wips_pkg;
	localparam int NL          = 32;
	localparam int DEPTH       = 70;
	localparam int HOLD_MARGIN = 4;
	localparam int HOLD_AT     = DEPTH - HOLD_MARGIN;
	localparam int FRAME_BITS  = 11;
	localparam int LINK_MBPS   = 100;
	localparam int CLK_MHZ     = 100;
	localparam int LAT_MAX_NS  = 1000;
	localparam int LAT_MAX_CYC = LAT_MAX_NS * CLK_MHZ / 1000;

	localparam logic [7:0]  TOK_PKT_END = 8'h01;
	localparam logic [7:0]  TOK_MSG_END = 8'h02;
	localparam logic [15:0] LFSR_SEED   = 16'hACE1;
	localparam logic [15:0] RMASK_RST   = 16'hFFFF;
	localparam logic [1:0]  ERR_PARITY  = 2'h1;
	localparam logic [1:0]  ERR_BADHDR  = 2'h2;

	localparam logic [11:0] REG_CTRL    = 12'h000;
	localparam logic [11:0] REG_START   = 12'h004;
	localparam logic [11:0] REG_FAULT   = 12'h008;
	localparam logic [11:0] REG_GROUP   = 12'h00C;
	localparam logic [11:0] REG_STRIP   = 12'h010;
	localparam logic [11:0] REG_DROP    = 12'h014;
	localparam logic [11:0] REG_RAND    = 12'h018;
	localparam logic [11:0] REG_RMASK   = 12'h01C;
	localparam logic [11:0] REG_BUSY    = 12'h020;
	localparam logic [11:0] REG_STARTED = 12'h024;
	localparam logic [3:0]  PAGE_BASE   = 4'h1;
	localparam logic [3:0]  PAGE_MASK   = 4'h2;
	localparam int          INV_BIT     = 16;
	localparam int          HLEN_BIT    = 0;

	typedef logic [6:0] ptr_t;

	typedef struct packed {
		logic       ctl;
		logic [7:0] data;
	} token_s;

	typedef struct packed {
		logic [NL-1:0] data;
		logic [NL-1:0] hold;
	} link_pins_s;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [31:0] writedata;
	} avm_req_s;

	typedef enum logic [2:0] {
		S_HDR   = 3'b000,
		S_ROUTE = 3'b001,
		S_HTX   = 3'b010,
		S_BODY  = 3'b011,
		S_DROP  = 3'b100
	} in_state_e;
endpackage

// file: hdl/wips_switch.sv
// 32-link wormhole switch with interval routing, register slave on Avalon-MM
// assumes link pins and link clock are asynchronous to i_clk_sys
// Operation
// RULE_01: any input link can reach any output link through a full crossbar
// RULE_02: every link runs its own logic; pairs never slow each other
// RULE_03: each link moves serial frames both ways, up to the link rate
// RULE_04: leading header routes; body follows until a terminator, any length
// RULE_05: header is the first one or two bytes, length set by software
// RULE_06: packet end and message end both forwarded and both close the route
// RULE_07: route chosen once the header is in; forwarding starts at once
// RULE_08: uncontended latency from first bit in to bit out under one microsecond
// RULE_09: each output holds a header interval; packet leaves where it falls
// RULE_10: intervals contiguous, lower bound included, upper bound excluded
// RULE_11: grouped consecutive outputs; first free member of group carries packet
// RULE_12: optional per-input mask restricts reachable outputs
// RULE_13: header falling in an invalid interval is discarded
// RULE_14: two-phase mode routes first to a random intermediate label
// RULE_15: per-output flag strips the header, exposing the next one
// RULE_16: at least 70 tokens buffered per path with full flow control
// RULE_17: command port sends reports upward; chain port feeds traffic in from below
// RULE_18: exactly one report per data link error on the command port
// RULE_19: drop-when-down output discards only after it started and then failed
// RULE_20: controller clears a parity fault before peers send to that link again
// RULE_21: controller ignores error reports caused by reset levels one and two
// RULE_22: crossbar path held until the terminator passes, then released
`timescale 1ns/100ps
module wips_switch (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst_b,
	input  wire logic                 i_link_clk,
	input  wire wips_pkg::link_pins_s i_link,
	output      wips_pkg::link_pins_s o_link,
	input  wire logic                 i_ctl_rx,
	output      logic                 o_ctl_tx,
	input  wire wips_pkg::avm_req_s   i_avm,
	output      logic [31:0]          o_avm_readdata,
	output      logic                 o_avm_waitrequest
);
	import wips_pkg::*;
	localparam int NR = NL + 1;

	logic          lclk_s1_reg, lclk_s2_reg, lclk_s3_reg, tick;
	logic [NR-1:0] rx_s1_reg, rx_s2_reg, rx_vld_reg, tx_bit_reg, tx_load, out_ok;
	logic [NL-1:0] hold_s1_reg, hold_s2_reg, hold_reg, push, pop, adv, offer, bad_evt;
	logic [9:0]    rx_sh_reg   [NR];
	logic [9:0]    rx_word_reg [NR];
	logic [3:0]    rx_cnt_reg  [NR];
	logic [10:0]   tx_sh_reg   [NR];
	logic [3:0]    tx_cnt_reg  [NR];
	token_s        tx_tok      [NR];
	token_s        mem         [NL][DEPTH];
	token_s        head        [NL];
	token_s        offer_tok   [NL];
	ptr_t          wp_reg [NL];
	ptr_t          rp_reg [NL];
	ptr_t          cnt_reg[NL];
	logic          hlen2_reg, wait_reg;
	logic [NL-1:0] group_reg, strip_reg, drop_reg, rand_reg, inv_reg, dd;
	logic [NL-1:0] fault_reg, started_reg, par_pend_reg, hdr_pend_reg, busy_reg;
	logic [NL-1:0] start_wr, par_clr, hdr_clr, grant, route_bad, route_drop;
	logic [15:0]   rmask_reg, lfsr_reg;
	logic [15:0]   base_reg [NL];
	logic [NL-1:0] mask_reg [NL];
	logic          chain_pend_reg, chain_clr, wr_do, rep_load;
	token_s        chain_tok_reg, rep_tok;
	logic [31:0]   rdata;
	in_state_e     st_reg   [NL];
	logic [15:0]   hdr_reg  [NL];
	logic [15:0]   lab      [NL];
	logic          hcnt_reg [NL];
	logic [4:0]    own_reg  [NL];
	logic [4:0]    owner_reg[NL];
	logic [4:0]    gsel     [NL];
	logic [4:0]    gid      [NL];
	logic [2:0]    nsend_reg[NL];
	logic [31:0]   sbuf_reg [NL];

	function automatic logic par_ok(input logic [9:0] w);
		return ~^w;
	endfunction

	function automatic ptr_t ptr_inc(input ptr_t p);
		return (p == ptr_t'(DEPTH - 1)) ? '0 : p + 7'h01;
	endfunction

	function automatic logic [5:0] find_iv(input logic [15:0] l);
		logic [5:0] r;
		r = '0;
		for (int j = 0; j < NL; j++) begin
			if (base_reg[j] <= l && ((j == NL - 1) || l < base_reg[(j + 1) % NL])) begin // RULE_10
				r = {1'b1, 5'(j)};
			end
		end
		return r;
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			{lclk_s1_reg, lclk_s2_reg, lclk_s3_reg} <= 3'h0;
			rx_s1_reg   <= '0;
			rx_s2_reg   <= '0;
			hold_s1_reg <= '0;
			hold_s2_reg <= '0;
		end else begin
			{lclk_s1_reg, lclk_s2_reg, lclk_s3_reg} <= {i_link_clk, lclk_s1_reg, lclk_s2_reg};
			rx_s1_reg   <= {i_ctl_rx, i_link.data};
			rx_s2_reg   <= rx_s1_reg;
			hold_s1_reg <= i_link.hold;
			hold_s2_reg <= hold_s1_reg;
		end
	end
	assign tick = lclk_s2_reg & ~lclk_s3_reg;

	// ************************************************************
	// serial receivers, index NL is the chain port
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		for (int k = 0; k < NR; k++) begin
			if (!i_rst_b) begin
				rx_cnt_reg[k]  <= 4'h0;
				rx_sh_reg[k]   <= 10'h000;
				rx_word_reg[k] <= 10'h000;
				rx_vld_reg[k]  <= 1'b0;
			end else begin
				rx_vld_reg[k] <= 1'b0;
				if (tick && rx_cnt_reg[k] == 4'h0) begin
					rx_cnt_reg[k] <= {3'h0, rx_s2_reg[k]}; // RULE_03
				end else if (tick) begin
					rx_sh_reg[k] <= {rx_sh_reg[k][8:0], rx_s2_reg[k]};
					if (rx_cnt_reg[k] == 4'(FRAME_BITS - 1)) begin
						rx_word_reg[k] <= {rx_sh_reg[k][8:0], rx_s2_reg[k]};
						rx_vld_reg[k]  <= 1'b1;
						rx_cnt_reg[k]  <= 4'h0;
					end else begin
						rx_cnt_reg[k] <= rx_cnt_reg[k] + 4'h1;
					end
				end
			end
		end
	end

	// ************************************************************
	// serial transmitters, index NL is the command port
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		for (int k = 0; k < NR; k++) begin
			if (!i_rst_b) begin
				tx_cnt_reg[k] <= 4'h0;
				tx_sh_reg[k]  <= 11'h000;
				tx_bit_reg[k] <= 1'b0;
			end else begin
				if (tick) tx_bit_reg[k] <= (tx_cnt_reg[k] != 4'h0) & tx_sh_reg[k][10];
				if (tx_load[k]) begin
					tx_sh_reg[k]  <= {1'b1, tx_tok[k], ^tx_tok[k]}; // RULE_03
					tx_cnt_reg[k] <= 4'(FRAME_BITS);
				end else if (tick && tx_cnt_reg[k] != 4'h0) begin
					tx_sh_reg[k]  <= {tx_sh_reg[k][9:0], 1'b0};
					tx_cnt_reg[k] <= tx_cnt_reg[k] - 4'h1;
				end
			end
		end
	end
	assign o_link   = '{data: tx_bit_reg[NL-1:0], hold: hold_reg};
	assign o_ctl_tx = tx_bit_reg[NL];

	// ************************************************************
	// input buffers with hold-off
	// ************************************************************
	always_comb begin
		for (int i = 0; i < NL; i++) begin
			head[i]    = mem[i][rp_reg[i]];
			bad_evt[i] = rx_vld_reg[i] & ~par_ok(rx_word_reg[i]) & ~fault_reg[i];
			push[i]    = rx_vld_reg[i] & par_ok(rx_word_reg[i]) & ~fault_reg[i] & (cnt_reg[i] < DEPTH);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < NL; i++) begin
			if (push[i]) begin
				mem[i][wp_reg[i]] <= rx_word_reg[i][9:1];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < NL; i++) begin
			if (!i_rst_b) begin
				wp_reg[i]   <= '0;
				rp_reg[i]   <= '0;
				cnt_reg[i]  <= '0;
				hold_reg[i] <= 1'b0;
			end else begin
				if (push[i]) wp_reg[i] <= ptr_inc(wp_reg[i]);
				if (pop[i]) rp_reg[i] <= ptr_inc(rp_reg[i]);
				cnt_reg[i]  <= cnt_reg[i] + ptr_t'(push[i]) - ptr_t'(pop[i]);
				hold_reg[i] <= (cnt_reg[i] >= ptr_t'(HOLD_AT)); // RULE_16
			end
		end
	end

	// ************************************************************
	// route decision and output allocation
	// ************************************************************
	always_comb begin
		logic [NL-1:0] taken;
		logic [NL-1:0] cand;
		logic [5:0]    f;
		taken = busy_reg;
		cand  = '0;
		f     = '0;
		gid[0] = 5'h00;
		for (int j = 1; j < NL; j++) gid[j] = group_reg[j] ? 5'(j) : gid[j-1]; // RULE_11
		for (int j = 0; j < NL; j++) dd[j] = drop_reg[j] & started_reg[j] & fault_reg[j]; // RULE_19
		for (int i = 0; i < NL; i++) begin
			lab[i] = rand_reg[i] ? (lfsr_reg & rmask_reg) : (hlen2_reg ? hdr_reg[i] : {8'h00, hdr_reg[i][7:0]}); // RULE_14
			f = find_iv(lab[i]); // RULE_09
			for (int k = 0; k < NL; k++) cand[k] = (gid[k] == gid[f[4:0]]) & mask_reg[i][k]; // RULE_12
			grant[i]      = 1'b0;
			gsel[i]       = 5'h00;
			route_bad[i]  = (st_reg[i] == S_ROUTE) & (~f[5] | inv_reg[f[4:0]] | (cand == '0)); // RULE_13
			route_drop[i] = (st_reg[i] == S_ROUTE) & ~route_bad[i] & dd[f[4:0]];
			if ((st_reg[i] == S_ROUTE) && !route_bad[i] && !route_drop[i] && cand[f[4:0]] && !taken[f[4:0]]) begin
				grant[i]      = 1'b1; // RULE_09
				gsel[i]       = f[4:0];
				taken[f[4:0]] = 1'b1;
			end
			for (int k = 0; k < NL; k++) begin
				if ((st_reg[i] == S_ROUTE) && !route_bad[i] && !route_drop[i] && !grant[i] && cand[k] && !taken[k]) begin
					grant[i] = 1'b1; // RULE_11
					gsel[i]  = 5'(k);
					taken[k] = 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// crossbar data path
	// ************************************************************
	always_comb begin
		for (int i = 0; i < NL; i++) begin
			offer[i]     = (st_reg[i] == S_HTX) ? (nsend_reg[i] != 3'h0) : ((st_reg[i] == S_BODY) & (cnt_reg[i] != '0));
			offer_tok[i] = (st_reg[i] == S_HTX) ? {1'b0, sbuf_reg[i][31:24]} : head[i];
		end
		for (int c = 0; c < NL; c++) begin
			out_ok[c]  = (tx_cnt_reg[c] == 4'h0) & ~hold_s2_reg[c]; // RULE_16
			tx_tok[c]  = offer_tok[owner_reg[c]]; // RULE_01
			tx_load[c] = busy_reg[c] & out_ok[c] & offer[owner_reg[c]]; // RULE_02
		end
		out_ok[NL]  = 1'b0;
		tx_tok[NL]  = rep_tok;
		tx_load[NL] = rep_load;
		for (int i = 0; i < NL; i++) begin
			adv[i] = offer[i] & out_ok[own_reg[i]];
			pop[i] = (cnt_reg[i] != '0) & ((st_reg[i] == S_HDR) | (st_reg[i] == S_DROP) | ((st_reg[i] == S_BODY) & adv[i]));
		end
	end

	always_ff @(posedge i_clk_sys) begin
		for (int c = 0; c < NL; c++) begin
			if (!i_rst_b) begin
				busy_reg[c]  <= 1'b0;
				owner_reg[c] <= 5'h00;
			end else if (busy_reg[c] && st_reg[owner_reg[c]] == S_BODY && adv[owner_reg[c]] && head[owner_reg[c]].ctl) begin
				busy_reg[c] <= 1'b0; // RULE_22
			end
			for (int i = 0; i < NL; i++) begin
				if (i_rst_b && grant[i] && gsel[i] == 5'(c)) begin
					busy_reg[c]  <= 1'b1;
					owner_reg[c] <= 5'(i);
				end
			end
		end
	end

	// ************************************************************
	// per-input packet state machines
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < NL; i++) begin
			if (!i_rst_b) begin
				st_reg[i]    <= S_HDR;
				hdr_reg[i]   <= 16'h0000;
				hcnt_reg[i]  <= 1'b0;
				own_reg[i]   <= 5'h00;
				nsend_reg[i] <= 3'h0;
				sbuf_reg[i]  <= 32'h00000000;
			end else begin
				unique case (st_reg[i])
					S_HDR: begin
						if (cnt_reg[i] != '0 && !head[i].ctl) begin
							hdr_reg[i] <= {hdr_reg[i][7:0], head[i].data}; // RULE_04
							hcnt_reg[i] <= ~hcnt_reg[i] & hlen2_reg;
							if (hcnt_reg[i] || !hlen2_reg) st_reg[i] <= S_ROUTE; // RULE_05
						end
					end
					S_ROUTE: begin
						if (route_bad[i] || route_drop[i]) begin
							st_reg[i] <= S_DROP; // RULE_13
						end else if (grant[i]) begin
							own_reg[i] <= gsel[i]; // RULE_07
							st_reg[i]  <= S_HTX;
							if (rand_reg[i] && !strip_reg[gsel[i]]) begin
								sbuf_reg[i]  <= hlen2_reg ? {lab[i], hdr_reg[i]} : {lab[i][7:0], hdr_reg[i][7:0], 16'h0000}; // RULE_14
								nsend_reg[i] <= hlen2_reg ? 3'h4 : 3'h2;
							end else if (rand_reg[i] || !strip_reg[gsel[i]]) begin
								sbuf_reg[i]  <= hlen2_reg ? {hdr_reg[i], 16'h0000} : {hdr_reg[i][7:0], 24'h000000};
								nsend_reg[i] <= hlen2_reg ? 3'h2 : 3'h1;
							end else begin
								nsend_reg[i] <= 3'h0; // RULE_15
							end
						end
					end
					S_HTX: begin
						if (nsend_reg[i] == 3'h0) begin
							st_reg[i] <= S_BODY; // RULE_08
						end else if (adv[i]) begin
							sbuf_reg[i]  <= {sbuf_reg[i][23:0], 8'h00};
							nsend_reg[i] <= nsend_reg[i] - 3'h1;
						end
					end
					S_BODY: begin
						if (adv[i] && head[i].ctl) st_reg[i] <= S_HDR; // RULE_06
					end
					S_DROP: begin
						if (cnt_reg[i] != '0 && head[i].ctl) st_reg[i] <= S_HDR; // RULE_06
					end
					default: st_reg[i] <= S_HDR;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) lfsr_reg <= LFSR_SEED;
		else lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
	end

	// ************************************************************
	// link faults and error reports
	// ************************************************************
	always_comb begin
		par_clr   = '0;
		hdr_clr   = '0;
		chain_clr = 1'b0;
		rep_tok   = chain_tok_reg;
		rep_load  = (tx_cnt_reg[NL] == 4'h0) & (chain_pend_reg | (|par_pend_reg) | (|hdr_pend_reg)); // RULE_17
		if (chain_pend_reg) begin
			chain_clr = rep_load;
		end else begin
			for (int i = NL - 1; i >= 0; i--) begin
				if (hdr_pend_reg[i] && par_pend_reg == '0) begin
					hdr_clr = '0;
					hdr_clr[i] = rep_load;
					rep_tok = {1'b0, ERR_BADHDR, 1'b0, 5'(i)};
				end
			end
			for (int i = NL - 1; i >= 0; i--) begin
				if (par_pend_reg[i]) begin
					par_clr = '0;
					par_clr[i] = rep_load;
					rep_tok = {1'b0, ERR_PARITY, 1'b0, 5'(i)}; // RULE_18
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			fault_reg      <= '0;
			started_reg    <= '0;
			par_pend_reg   <= '0;
			hdr_pend_reg   <= '0;
			chain_pend_reg <= 1'b0;
			chain_tok_reg  <= '0;
		end else begin
			fault_reg      <= (fault_reg & ~start_wr) | bad_evt; // RULE_19
			started_reg    <= started_reg | start_wr;
			par_pend_reg   <= (par_pend_reg & ~par_clr) | bad_evt; // RULE_18
			hdr_pend_reg   <= (hdr_pend_reg & ~hdr_clr) | route_bad;
			chain_pend_reg <= (chain_pend_reg & ~chain_clr) | (rx_vld_reg[NL] & par_ok(rx_word_reg[NL])); // RULE_17
			if (rx_vld_reg[NL]) chain_tok_reg <= rx_word_reg[NL][9:1];
		end
	end

	// ************************************************************
	// avalon register slave
	// ************************************************************
	assign wr_do    = i_avm.write & ~wait_reg;
	assign start_wr = (wr_do && i_avm.address == REG_START) ? i_avm.writedata : '0;
	always_comb begin
		unique case (i_avm.address)
			REG_CTRL:    rdata = {31'h00000000, hlen2_reg};
			REG_FAULT:   rdata = fault_reg;
			REG_GROUP:   rdata = group_reg;
			REG_STRIP:   rdata = strip_reg;
			REG_DROP:    rdata = drop_reg;
			REG_RAND:    rdata = rand_reg;
			REG_RMASK:   rdata = {16'h0000, rmask_reg};
			REG_BUSY:    rdata = busy_reg;
			REG_STARTED: rdata = started_reg;
			default: begin
				if (i_avm.address[11:8] == PAGE_BASE) rdata = {15'h0000, inv_reg[i_avm.address[6:2]], base_reg[i_avm.address[6:2]]};
				else if (i_avm.address[11:8] == PAGE_MASK) rdata = mask_reg[i_avm.address[6:2]];
				else rdata = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			wait_reg       <= 1'b1;
			o_avm_readdata <= 32'h00000000;
		end else if ((i_avm.read || i_avm.write) && wait_reg) begin
			wait_reg       <= 1'b0;
			o_avm_readdata <= rdata;
		end else begin
			wait_reg <= 1'b1;
		end
	end
	assign o_avm_waitrequest = wait_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			hlen2_reg <= 1'b0;
			group_reg <= '1;
			{strip_reg, drop_reg, rand_reg, inv_reg} <= '0;
			rmask_reg <= RMASK_RST;
			for (int j = 0; j < NL; j++) begin
				base_reg[j] <= 16'h0000;
				mask_reg[j] <= '1;
			end
		end else if (wr_do) begin
			unique case (i_avm.address)
				REG_CTRL:  hlen2_reg <= i_avm.writedata[HLEN_BIT]; // RULE_05
				REG_GROUP: group_reg <= i_avm.writedata;
				REG_STRIP: strip_reg <= i_avm.writedata; // RULE_15
				REG_DROP:  drop_reg <= i_avm.writedata;
				REG_RAND:  rand_reg <= i_avm.writedata;
				REG_RMASK: rmask_reg <= i_avm.writedata[15:0];
				default: begin
					if (i_avm.address[11:8] == PAGE_BASE) begin
						base_reg[i_avm.address[6:2]] <= i_avm.writedata[15:0]; // RULE_09
						inv_reg[i_avm.address[6:2]]  <= i_avm.writedata[INV_BIT];
					end else if (i_avm.address[11:8] == PAGE_MASK) begin
						mask_reg[i_avm.address[6:2]] <= i_avm.writedata; // RULE_12
					end
				end
			endcase
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	logic ovf, own_bad;
	always_comb begin
		ovf     = 1'b0;
		own_bad = 1'b0;
		for (int i = 0; i < NL; i++) begin
			ovf     = ovf | (cnt_reg[i] > DEPTH);
			own_bad = own_bad | (busy_reg[i] & (st_reg[owner_reg[i]] != S_HTX) & (st_reg[owner_reg[i]] != S_BODY));
		end
	end
	default clocking dcb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	sequence req_taken;
		(i_avm.read || i_avm.write) && o_avm_waitrequest;
	endsequence
	sequence ack_once;
		!o_avm_waitrequest ##1 o_avm_waitrequest;
	endsequence
	a_bus_answer: assert property (req_taken |=> ack_once) else $error("bus answer not one cycle");
	a_fifo_bound: assert property (!ovf) else $error("buffer count past depth"); // RULE_16
	a_hold_flow: assert property (cnt_reg[0] >= ptr_t'(HOLD_AT) |=> o_link.hold[0]) else $error("no hold"); // RULE_16
	a_fault_report: assert property (bad_evt[1] |=> fault_reg[1] && par_pend_reg[1]) else $error("no fault"); // RULE_18
	a_route_owner: assert property (!own_bad) else $error("output held by idle input"); // RULE_22
	a_bad_discard: assert property (route_bad[0] |=> st_reg[0] == S_DROP && hdr_pend_reg[0]) else $error("bad hdr"); // RULE_13
	a_down_discard: assert property (route_drop[0] |=> st_reg[0] == S_DROP) else $error("down link not dropped"); // RULE_19
	a_report_frame: assert property (tx_load[NL] |=> tx_cnt_reg[NL] == 4'(FRAME_BITS)) else $error("report frame"); // RULE_18
	a_cut_through: assert property (st_reg[0] == S_HTX && adv[0] |=> tx_cnt_reg[own_reg[0]] != 4'h0)
		else $error("header not forwarded"); // RULE_07
endmodule

// file: dv/wips_peer.sv
// far end of one serial link: frame sender and frame decoder
// assumes the bench's free-running shared link clock
`timescale 1ns/100ps
module wips_peer (
	input  wire logic       i_clk_sys,
	input  wire logic       i_link_clk,
	input  wire logic       i_rx,
	input  wire logic       i_hold,
	output      logic       o_tx,
	output      logic [8:0] o_tok,
	output      logic       o_stb
);
	logic [9:0] sh;
	int         n = 0;
	initial begin
		o_tx = 1'b0;
		o_tok = '0;
		o_stb = 1'b0;
	end
	// ****
	// decode: start bit, 9 bits msb first, even parity
	// ****
	always @(negedge i_link_clk) begin
		if (n > 0) begin
			sh = {sh[8:0], i_rx};
			n = n - 1;
			if (n == 0) begin
				o_tok = (^sh) ? 9'h1FF : sh[9:1];
				o_stb = !o_stb;
			end
		end else if (i_rx === 1'b1) begin
			n = 10;
		end
	end
	// ****
	// send: bit 9 of t flips parity on purpose
	// ****
	task automatic send(input logic [9:0] t);
		logic [10:0] f;
		f = {1'b1, t[8:0], ^t};
		while (i_hold === 1'b1) @(posedge i_clk_sys);
		for (int b = 10; b >= -1; b--) begin
			@(negedge i_link_clk);
			@(posedge i_clk_sys);
			o_tx <= (b >= 0) ? f[b] : 1'b0;
		end
	endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the packet switch
// assumes a peer on every data link and on the control ports
`timescale 1ns/100ps
module tb_top;
	import wips_pkg::*;
	localparam logic [9:0] PE = {2'b01, TOK_PKT_END};
	localparam logic [9:0] ME = {2'b01, TOK_MSG_END};
	logic        i_clk_sys;
	logic        i_rst_b;
	logic        i_link_clk;
	avm_req_s    avm;
	link_pins_s  lout;
	logic [31:0] rdata;
	logic [31:0] bq;
	logic        wreq;
	logic        o_ctl_tx;
	wire  [NL:0] tx;
	wire  [NL:0] stb;
	wire  [8:0]  tok [NL+1];
	wire  [NL:0] rxv = {o_ctl_tx, lout.data};
	wire  [NL:0] hv = {1'b0, lout.hold};
	logic [8:0]  rq [NL+1][$];
	logic [9:0]  sq [NL+1][$];
	logic [9:0]  fq [$];
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;
	wips_switch u_dut (
		.i_clk_sys        (i_clk_sys),
		.i_rst_b          (i_rst_b),
		.i_link_clk       (i_link_clk),
		.i_link           ({tx[NL-1:0], {NL{1'b0}}}),
		.o_link           (lout),
		.i_ctl_rx         (tx[NL]),
		.o_ctl_tx         (o_ctl_tx),
		.i_avm            (avm),
		.o_avm_readdata   (rdata),
		.o_avm_waitrequest(wreq)
	);
	for (genvar k = 0; k <= NL; k++) begin : g_peer
		wips_peer u_p (
			.i_clk_sys (i_clk_sys),
			.i_link_clk(i_link_clk),
			.i_rx      (rxv[k]),
			.i_hold    (hv[k]),
			.o_tx      (tx[k]),
			.o_tok     (tok[k]),
			.o_stb     (stb[k])
		);
		always @(stb[k]) rq[k].push_back(tok[k]);
		initial forever begin
			wait (sq[k].size() > 0);
			u_p.send(sq[k][0]);
			sq[k].delete(0);
		end
	end
	// ****
	// clocks, timeout, tasks
	// ****
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_link_clk = 1'b0;
		#3;
		forever #80 i_link_clk = ~i_link_clk;
	end
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_tok(input int k, input logic [9:0] e[$]);
		int t;
		foreach (e[i]) begin
			t = 0;
			while (rq[k].size() == 0 && t < 3000) begin
				@(posedge i_clk_sys);
				t++;
			end
			chk((rq[k].size() > 0) ? rq[k].pop_front() : 9'hxxx, e[i]);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		avm <= '{read: !w, write: w, address: a, writedata: d};
		do begin
			@(posedge i_clk_sys);
		end while (wreq !== 1'b0);
		bq = rdata;
		avm <= '0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(bq, e);
	endtask
	task automatic put(input int k, input logic [9:0] t[$]);
		foreach (t[i]) sq[k].push_back(t[i]);
	endtask
	function automatic logic [11:0] ba(input int j);
		return {PAGE_BASE, 6'(j), 2'b00};
	endfunction
	// ****
	// main sequence
	// ****
	initial begin
		avm = '0;
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		foreach (rq[k]) rq[k].delete();
		rd(REG_RMASK, {16'h0, RMASK_RST});
		rd(REG_GROUP, 32'hFFFFFFFF);
		rd({PAGE_MASK, 8'h00}, 32'hFFFFFFFF);
		rd(REG_BUSY, 32'h0);
		wr(12'hFFC, 32'h1);
		rd(12'hFFC, 32'h0);
		for (int j = 0; j < NL; j++) wr(ba(j), j * 16);
		rd(ba(31), 32'h1F0);
		wr(REG_START, 32'hFFFFFFFF);
		put(0, {10'h02F, 10'h0AB, PE, 10'h030, 10'h0CD, ME});
		chk_tok(2, {10'h02F, 10'h0AB, PE});
		chk_tok(3, {10'h030, 10'h0CD, ME});
		wr(REG_STRIP, 32'h10);
		put(0, {10'h041, 10'h05A, PE});
		chk_tok(4, {10'h05A, PE});
		wr(REG_CTRL, 32'h1);
		put(0, {10'h000, 10'h055, 10'h077, ME});
		chk_tok(5, {10'h000, 10'h055, 10'h077, ME});
		wr(REG_CTRL, 32'h0);
		wr(ba(6), 32'h10060);
		put(0, {10'h06A, 10'h0BB, PE});
		chk_tok(NL, {10'h080});
		wr(ba(6), 32'h60);
		wr({PAGE_MASK, 8'h00}, 32'hFFFFFF7F);
		put(0, {10'h071, 10'h0BB, PE, 10'h061, PE});
		chk_tok(NL, {10'h080});
		chk_tok(6, {10'h061, PE});
		wr({PAGE_MASK, 8'h00}, 32'hFFFFFFFF);
		put(1, {10'h20F});
		chk_tok(NL, {10'h041});
		rd(REG_FAULT, 32'h2);
		wr(REG_DROP, 32'h2);
		put(0, {10'h012, 10'h0EE, PE});
		put(NL, {10'h033});
		chk_tok(NL, {10'h033});
		wr(REG_START, 32'h2);
		rd(REG_FAULT, 32'h0);
		put(0, {10'h013, PE});
		chk_tok(1, {10'h013, PE});
		wr(REG_RMASK, 32'h0);
		wr(REG_RAND, 32'h8);
		put(3, {10'h025, 10'h011, ME});
		chk_tok(0, {10'h000, 10'h025, 10'h011, ME});
		put(8, {10'h095, 10'h0A1, PE});
		put(9, {10'h085, 10'h0A2, PE});
		chk_tok(9, {10'h095, 10'h0A1, PE});
		chk_tok(8, {10'h085, 10'h0A2, PE});
		wr(REG_GROUP, 32'hFFFFF7FF);
		put(12, {10'h0A0, 10'h001});
		chk_tok(10, {10'h0A0});
		rd(REG_BUSY, 32'h400);
		put(13, {10'h0A5, 10'h002, PE});
		chk_tok(11, {10'h0A5, 10'h002, PE});
		put(12, {PE});
		chk_tok(10, {10'h001, PE});
		rd(REG_BUSY, 32'h0);
		put(16, {10'h0C0});
		chk_tok(12, {10'h0C0});
		repeat (69) fq.push_back(10'h0C1);
		fq.push_back(PE);
		put(0, fq);
		repeat (15000) @(posedge i_clk_sys);
		chk(lout.hold, 32'h1);
		put(16, {PE});
		fq.push_front(PE);
		chk_tok(12, fq);
		chk(lout.hold, 32'h0);
		report_and_stop();
	end
endmodule
